// file: sb_cmd_defines.svh
// constants for the sideband multicast and flow-control command block
`ifndef SB_CMD_DEFINES_SVH
`define SB_CMD_DEFINES_SVH
`define CMD_DISABLE_MCAST      8'h13
`define CMD_SET_FLOWCTL        8'h14
`define CMD_GET_VERSION        8'h15
`define RSP_FLAG               8'h80
`define PKT_LAST_BYTE          8'h2D
`define CHAN_PACKAGE_WIDE      5'h1F
`define FC_OFF                 8'h00
`define FC_GEN                 8'h01
`define FC_HONOUR              8'h02
`define FC_BOTH                8'h03
`define RC_COMPLETED           16'h0000
`define RC_FAILED              16'h0001
`define REASON_NONE            16'h0000
`define REASON_PARAM           16'h0002
`define REASON_UNSUPPORTED     16'h0003
`define REASON_FC_INDEPENDENT  16'h1409
`define MC_ENTRIES             8
`define MC_IDX_W               3
`define ACCEPT_ALL_MCAST_CAP   1'b1
`define FC_INDEPENDENT_CAP     1'b1
`endif

// file: sb_cmd_device.sv
// device end: serves disable-multicast, set-flow-control and get-version
// Behaviour
// - disable command forwards every multicast frame
// - disable only when accept-all-multicast exists
// - otherwise accept only enabled filter matches
// - disable command is header, checksum, pad
// - error-free disable answered with type 0x93
// - disable response uses generic reasons only
// - set-flow-control 0x14 configures pause frames
// - flow control addressed package-wide, channel 0x1F
// - pause setting independent of arbitration
// - enable field in low byte of word
// - zero disables all flow control
// - value 1 generates pause frames
// - value 2 honours received pause frames
// - value 3 enables both directions
// - good set-flow-control answered with 0x94
// - flow response carries code and reason word
// - joint-only package returns reason 0x1409
// - get-version command is header, checksum, pad
// - error-free get-version answered with 0x95
`timescale 1ns/100ps
`default_nettype none
`include "sb_cmd_defines.svh"
module sb_cmd_device
(
	input  wire logic                    core_clk,
	input  wire logic                    resetn,
	sb_cmd_if.device                     link,
	input  wire logic [2:0]              own_pkg_id,
	input  wire logic [4:0]              own_chan_id,
	input  wire logic                    frame_is_mcast,
	input  wire logic [`MC_ENTRIES-1:0]  entry_enable,
	input  wire logic [`MC_ENTRIES-1:0]  entry_match,
	output logic                         mcast_accept,
	output logic                         global_mcast,
	output logic                         pause_generate,
	output logic                         pause_honour
);
	import sb_cmd_pkg::*;
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_RESP = 2'b01
	} dev_state_t;
	typedef struct packed
	{
		dev_state_t  state;
		logic        gmc;
		logic        gen;
		logic        hon;
		logic        acc;
		sb_rsp_t     rsp;
	} dev_regs_t;
	dev_regs_t r;
	dev_regs_t next_r;
	logic      addr_ok;
	logic      pkg_ok;
	logic      take;
	logic      mcast_cap;
	logic      fc_joint_only;
	logic      fc_one_way;
	logic      fc_reserved;
	logic      gate_accept;

	// per-channel commands need both halves of the identifier to match
	assign addr_ok = (link.cmd.pkg_id == own_pkg_id)
		&& (link.cmd.chan_id == own_chan_id);
	// flow control is a package command, channel field must be the wildcard
	assign pkg_ok = (link.cmd.pkg_id == own_pkg_id)
		&& (link.cmd.chan_id == `CHAN_PACKAGE_WIDE);
	// a bad checksum is taken off the link and never answered
	assign take = link.cmd_valid && link.cmd.csum_ok;
	// capability straps; a build without them refuses disable and the one-way flow-control settings
	assign mcast_cap = `ACCEPT_ALL_MCAST_CAP;
	assign fc_joint_only = !`FC_INDEPENDENT_CAP;
	assign fc_one_way = (link.cmd.fc_enable == `FC_GEN)
		|| (link.cmd.fc_enable == `FC_HONOUR);
	// 0x04 and up carry no setting, so the one in force is kept
	assign fc_reserved = (link.cmd.fc_enable > `FC_BOTH);

	always_comb
	begin
		next_r = r;
		// the filter decision is registered like every other data output
		next_r.acc = gate_accept;
		case (r.state)
			ST_IDLE:
			begin
				if (take)
				begin
					next_r.rsp.rsp_type = link.cmd.cmd_type | `RSP_FLAG;
					next_r.rsp.rsp_code = `RC_COMPLETED;
					next_r.rsp.reason = `REASON_NONE;
					case (link.cmd.cmd_type)
						`CMD_DISABLE_MCAST:
						begin
							if (addr_ok && mcast_cap)
							begin
								next_r.gmc = 1'b1;
								next_r.state = ST_RESP;
							end
							else if (addr_ok)
							begin
								next_r.rsp.rsp_code = `RC_FAILED;
								next_r.rsp.reason = `REASON_UNSUPPORTED;
								next_r.state = ST_RESP;
							end
						end
						`CMD_SET_FLOWCTL:
						begin
							if (pkg_ok)
							begin
								next_r.state = ST_RESP;
								if (fc_reserved)
								begin
									next_r.rsp.rsp_code = `RC_FAILED;
									next_r.rsp.reason = `REASON_PARAM;
								end
								else if (fc_one_way && fc_joint_only)
								begin
									next_r.rsp.rsp_code = `RC_FAILED;
									next_r.rsp.reason = `REASON_FC_INDEPENDENT;
								end
								else
								begin
									// setting is applied directly, no arbitration gating
									case (link.cmd.fc_enable)
										`FC_GEN:
										begin
											next_r.gen = 1'b1;
											next_r.hon = 1'b0;
										end
										`FC_HONOUR:
										begin
											next_r.gen = 1'b0;
											next_r.hon = 1'b1;
										end
										`FC_BOTH:
										begin
											next_r.gen = 1'b1;
											next_r.hon = 1'b1;
										end
										default:
										begin
											next_r.gen = 1'b0;
											next_r.hon = 1'b0;
										end
									endcase
								end
							end
						end
						`CMD_GET_VERSION:
						begin
							if (addr_ok)
							begin
								next_r.state = ST_RESP;
							end
						end
						default:
						begin
							next_r.state = ST_IDLE;
						end
					endcase
				end
			end
			ST_RESP:
			begin
				if (link.rsp_ready)
				begin
					next_r.state = ST_IDLE;
				end
			end
			default:
			begin
				next_r.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			r <= '0;
		end
		else
		begin
			r <= next_r;
		end
	end

	// commands failing checksum or address are dropped silently
	assign link.cmd_ready = (r.state == ST_IDLE);
	assign link.rsp_valid = (r.state == ST_RESP);
	assign link.rsp = r.rsp;
	assign global_mcast = r.gmc;
	assign pause_generate = r.gen;
	assign pause_honour = r.hon;
	assign mcast_accept = r.acc;

	sb_mcast_gate u_gate
	(
		.global_accept  (r.gmc),
		.frame_is_mcast (frame_is_mcast),
		.entry_enable   (entry_enable),
		.entry_match    (entry_match),
		.accept         (gate_accept)
	);
endmodule
`default_nettype wire

// file: sb_cmd_if.sv
// link carrying decoded commands and their responses
`timescale 1ns/100ps
`default_nettype none
interface sb_cmd_if;
	import sb_cmd_pkg::*;
	logic    cmd_valid;
	logic    cmd_ready;
	sb_cmd_t cmd;
	logic    rsp_valid;
	logic    rsp_ready;
	sb_rsp_t rsp;
	modport device (input cmd_valid, output cmd_ready, input cmd, output rsp_valid,
		input rsp_ready, output rsp);
	modport manager (output cmd_valid, input cmd_ready, output cmd, input rsp_valid,
		output rsp_ready, input rsp);
endinterface
`default_nettype wire

// file: sb_cmd_link_asserts.sv
// checker watching the command link between both ends
`timescale 1ns/100ps
`default_nettype none
module sb_cmd_link_asserts
(
	input wire logic                core_clk,
	input wire logic                resetn,
	input wire logic                cmd_valid,
	input wire logic                cmd_ready,
	input wire sb_cmd_pkg::sb_cmd_t cmd,
	input wire logic                rsp_valid,
	input wire logic                rsp_ready,
	input wire sb_cmd_pkg::sb_rsp_t rsp
);
	import sb_cmd_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	a_rsp_after_take: assert property ($rose(rsp_valid) |-> $past(cmd_valid && cmd_ready))
		else $error("response without a taken command");
	a_rsp_one_cycle: assert property (rsp_valid && rsp_ready |=> !rsp_valid)
		else $error("response repeated after handshake");
	a_busy_refuse: assert property (rsp_valid |-> !cmd_ready)
		else $error("command accepted while answering");
	a_rsp_type_match: assert property (cmd_valid && cmd_ready ##1 rsp_valid
		|-> rsp.rsp_type == ($past(cmd.cmd_type) | 8'h80)) else $error("wrong response type");
	a_disable_ok: assert property (rsp_valid && rsp.rsp_type == 8'h93
		|-> rsp.rsp_code == 16'h0000 && rsp.reason == 16'h0000) else $error("disable failed");
	a_version_ok: assert property (rsp_valid && rsp.rsp_type == 8'h95
		|-> rsp.rsp_code == 16'h0000 && rsp.reason == 16'h0000) else $error("version failed");
	a_fc_reason_pair: assert property (rsp_valid && rsp.rsp_type == 8'h94
		|-> {rsp.rsp_code, rsp.reason} inside {32'h00000000, 32'h00010002})
		else $error("bad flow control code");
	a_fc_pkg_wide: assert property (cmd_valid && cmd.cmd_type == 8'h14 |-> cmd.chan_id == 5'h1F)
		else $error("flow control not package wide");
endmodule
`default_nettype wire

// file: sb_cmd_manager.sv
// management-controller end: issues one command and collects its response
`timescale 1ns/100ps
`default_nettype none
`include "sb_cmd_defines.svh"
module sb_cmd_manager
(
	input  wire logic                  core_clk,
	input  wire logic                  resetn,
	sb_cmd_if.manager                  link,
	input  wire logic                  req_valid,
	output logic                       req_ready,
	input  wire logic [7:0]            req_type,
	input  wire logic [2:0]            req_pkg,
	input  wire logic [4:0]            req_chan,
	input  wire logic [7:0]            req_fc_enable,
	output logic                       done,
	output logic [15:0]                done_code,
	output logic [15:0]                done_reason,
	output logic [7:0]                 done_type
);
	import sb_cmd_pkg::*;
	typedef enum logic [1:0]
	{
		MS_IDLE = 2'b00,
		MS_SEND = 2'b01,
		MS_WAIT = 2'b11
	} mgr_state_t;
	typedef struct packed
	{
		mgr_state_t  state;
		sb_cmd_t     cmd;
		logic        done;
		sb_rsp_t     rsp;
	} mgr_regs_t;
	mgr_regs_t r;
	mgr_regs_t next_r;
	always_comb
	begin
		next_r = r;
		next_r.done = 1'b0;
		case (r.state)
			MS_IDLE:
			begin
				if (req_valid)
				begin
					next_r.cmd.cmd_type = req_type;
					next_r.cmd.pkg_id = req_pkg;
					// package-wide command always carries the wildcard channel
					next_r.cmd.chan_id = (req_type == `CMD_SET_FLOWCTL)
						? `CHAN_PACKAGE_WIDE : req_chan;
					next_r.cmd.fc_enable = req_fc_enable;
					next_r.cmd.csum_ok = 1'b1;
					next_r.state = MS_SEND;
				end
			end
			MS_SEND:
			begin
				if (link.cmd_ready)
				begin
					next_r.state = MS_WAIT;
				end
			end
			MS_WAIT:
			begin
				if (link.rsp_valid)
				begin
					next_r.rsp = link.rsp;
					next_r.done = 1'b1;
					next_r.state = MS_IDLE;
				end
			end
			default:
			begin
				next_r.state = MS_IDLE;
			end
		endcase
	end
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			r <= '0;
		end
		else
		begin
			r <= next_r;
		end
	end
	// a command the device drops leaves this end waiting; reset recovers it
	assign req_ready = (r.state == MS_IDLE);
	assign link.cmd_valid = (r.state == MS_SEND);
	assign link.cmd = r.cmd;
	assign link.rsp_ready = (r.state == MS_WAIT);
	assign done = r.done;
	assign done_code = r.rsp.rsp_code;
	assign done_reason = r.rsp.reason;
	assign done_type = r.rsp.rsp_type;
endmodule
`default_nettype wire

// file: sb_cmd_pkg.sv
// types shared by both ends of the command link
`default_nettype none
package sb_cmd_pkg;
	typedef struct packed
	{
		logic [7:0]  cmd_type;
		logic [2:0]  pkg_id;
		logic [4:0]  chan_id;
		logic [7:0]  fc_enable;
		logic        csum_ok;
	} sb_cmd_t;
	typedef struct packed
	{
		logic [7:0]  rsp_type;
		logic [15:0] rsp_code;
		logic [15:0] reason;
	} sb_rsp_t;
endpackage
`default_nettype wire

// file: sb_mcast_gate.sv
// multicast pass-through accept decision
`timescale 1ns/100ps
`default_nettype none
`include "sb_cmd_defines.svh"
module sb_mcast_gate
(
	input  wire logic                     global_accept,
	input  wire logic                     frame_is_mcast,
	input  wire logic [`MC_ENTRIES-1:0]   entry_enable,
	input  wire logic [`MC_ENTRIES-1:0]   entry_match,
	output logic                          accept
);
	logic [`MC_ENTRIES-1:0] hit;
	genvar i;
	generate
		for (i = 0; i < `MC_ENTRIES; i++)
		begin : g_entry
			assign hit[i] = entry_enable[i] & entry_match[i];
		end
	endgenerate
	// unicast is not this gate's concern and always passes here
	assign accept = !frame_is_mcast || global_accept || (|hit);
endmodule
`default_nettype wire

// file: test_sideband_mcast_flowctl_cmds.sv
// self-checking bench for both ends of the command link
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module test_sideband_mcast_flowctl_cmds;
	import sb_cmd_pkg::*;
	localparam logic [2:0] OWN_PKG = 3'h5;
	localparam logic [4:0] OWN_CHAN = 5'h02;
	localparam logic [7:0] FCS [7] = '{8'h03, 8'h04, 8'hFF, 8'h00, 8'h01, 8'h02, 8'h00};
	logic        core_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        req_valid = 1'b0;
	logic [7:0]  req_type = 8'h00;
	logic [2:0]  req_pkg = 3'h0;
	logic [4:0]  req_chan = 5'h00;
	logic [7:0]  req_fc_enable = 8'h00;
	logic        frame_is_mcast = 1'b0;
	logic [7:0]  entry_enable = 8'h00;
	logic [7:0]  entry_match = 8'h00;
	logic        req_ready, done, mcast_accept, global_mcast, pause_generate, pause_honour;
	logic [15:0] done_code, done_reason;
	logic [7:0]  done_type;
	logic        m_gm, m_gen, m_hon;
	int          fails = 0;
	int          num_checks = 0;
	int          seed = 32'h30F5;
	always #4 core_clk = ~core_clk;
	sb_cmd_if link ();
	sb_cmd_device sb_cmd_device_inst (.core_clk(core_clk), .resetn(resetn), .link(link),
		.own_pkg_id(OWN_PKG), .own_chan_id(OWN_CHAN), .frame_is_mcast(frame_is_mcast),
		.entry_enable(entry_enable), .entry_match(entry_match), .mcast_accept(mcast_accept),
		.global_mcast(global_mcast), .pause_generate(pause_generate), .pause_honour(pause_honour));
	sb_cmd_manager sb_cmd_manager_inst (.core_clk(core_clk), .resetn(resetn), .link(link),
		.req_valid(req_valid), .req_ready(req_ready), .req_type(req_type), .req_pkg(req_pkg),
		.req_chan(req_chan), .req_fc_enable(req_fc_enable), .done(done), .done_code(done_code),
		.done_reason(done_reason), .done_type(done_type));
	sb_cmd_link_asserts sb_cmd_link_asserts_inst (.core_clk(core_clk), .resetn(resetn),
		.cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready), .cmd(link.cmd),
		.rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready), .rsp(link.rsp));
	task automatic stop_test();
		if (fails == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic do_reset(input int n);
		@(posedge core_clk);
		#1 resetn = 1'b0;
		repeat (n) @(posedge core_clk);
		#1 resetn = 1'b1;
		{m_gm, m_gen, m_hon} = 3'b000;
	endtask
	function automatic logic want_accept(input logic mc, input logic gm, input logic [7:0] en,
		input logic [7:0] mt);
		return !mc || gm || (|(en & mt));
	endfunction
	// the accept decision is registered, so it is looked at one clock after the frame
	task automatic frames(input int n);
		logic want;
		repeat (n)
		begin
			@(posedge core_clk);
			#1 {frame_is_mcast, entry_enable, entry_match} = 17'($random(seed))
				& {9'h1FF, 8'($random(seed))};
			want = want_accept(frame_is_mcast, m_gm, entry_enable, entry_match);
			@(posedge core_clk) #1 `CHK(mcast_accept, want)
		end
	endtask
	// a dropped command gets no answer, so the manager is reset afterwards to avoid a hang
	task automatic send(input logic [7:0] t, input logic [2:0] p, input logic [4:0] c,
		input logic [7:0] f);
		int   n;
		logic hit;
		logic bad;
		hit = p == OWN_PKG && (t == 8'h14 || (c == OWN_CHAN && (t == 8'h13 || t == 8'h15)));
		bad = t == 8'h14 && f > 8'h03;
		@(posedge core_clk);
		#1 {req_valid, req_type, req_pkg, req_chan, req_fc_enable} = {1'b1, t, p, c, f};
		for (n = 0; req_ready !== 1'b1 && n < 10; n++)
			@(posedge core_clk) #1;
		if (n == 10)
		begin
			fails++;
			stop_test();
		end
		@(posedge core_clk);
		#1 req_valid = 1'b0;
		for (n = 0; done !== 1'b1 && n < 12; n++)
			@(posedge core_clk) #1;
		`CHK(done, hit)
		if (done !== hit && hit)
			stop_test();
		if (hit)
		begin
			`CHK(done_type, t | 8'h80)
			`CHK({done_code, done_reason}, bad ? 32'h00010002 : 32'h00000000)
			m_gm = m_gm || t == 8'h13;
			if (t == 8'h14 && !bad)
				{m_hon, m_gen} = f[1:0];
		end
		`CHK({global_mcast, pause_generate, pause_honour}, {m_gm, m_gen, m_hon})
		if (!hit)
			do_reset(2);
	endtask
	initial
	begin
		do_reset(20);
		frames(20);
		send(8'h13, OWN_PKG + 3'h1, OWN_CHAN, 8'h00);
		send(8'h16, OWN_PKG, OWN_CHAN, 8'h00);
		send(8'h13, OWN_PKG, OWN_CHAN, 8'h00);
		frames(10);
		for (int i = 0; i < 7; i++)
			send(8'h14, OWN_PKG, 5'h00, FCS[i]);
		send(8'h14, OWN_PKG + 3'h1, 5'h1F, 8'h01);
		send(8'h15, OWN_PKG, OWN_CHAN + 5'h01, 8'h00);
		repeat (40)
			send(8'h13 + 8'({$random(seed)} % 3), ($random(seed) & 1) ? OWN_PKG : 3'($random(seed)),
				($random(seed) & 1) ? OWN_CHAN : 5'($random(seed)), 8'($random(seed)) & 8'h07);
		frames(10);
		stop_test();
	end
endmodule
`default_nettype wire
